// file: fmrc_pkg.sv
package fmrc_pkg;

	// opcodes seen by the mode and reset control
	localparam logic [7:0] OP_CONT_EXIT = 8'hFF;
	localparam logic [7:0] OP_QPI_ENTER = 8'h38;
	localparam logic [7:0] OP_RST_ARM = 8'h66;
	localparam logic [7:0] OP_RST_EXEC = 8'h99;
	localparam logic [7:0] OP_DUAL_READ = 8'hBB;
	localparam logic [7:0] OP_QUAD_READ = 8'hEB;

	// phase lengths in bits, and the opcode window length in link clocks
	localparam logic [5:0] OPC_BITS = 6'h08;
	localparam logic [5:0] ADDR_BITS = 6'h18;
	localparam logic [5:0] MODE_BITS = 6'h08;
	localparam logic [3:0] OPC_CLKS_SPI = 4'h8;
	localparam logic [3:0] OPC_CLKS_QPI = 4'h2;
	localparam logic [1:0] CONT_KEEP = 2'h2;
	localparam int MODE_SKIP_HI = 5;
	localparam int MODE_SKIP_LO = 4;

	// register map (byte offsets as printed)
	localparam logic [7:0] OFS_VMAX = 8'h60;
	localparam logic [7:0] OFS_VMIN = 8'h62;
	localparam logic [7:0] OFS_FEAT = 8'h64;
	localparam logic [7:0] OFS_WRAP_OPC = 8'h66;
	localparam logic [7:0] OFS_WRAP_LEN = 8'h67;
	localparam logic [7:0] OFS_LOCK = 8'h68;
	localparam logic [7:0] OFS_CTRL = 8'h70;
	localparam logic [7:0] OFS_STAT = 8'h71;

	localparam logic [15:0] VMAX_VAL = 16'h3600;
	localparam logic [15:0] VMIN_VAL = 16'h2700;
	localparam logic [15:0] FEAT_VAL = 16'hF99F;
	localparam logic [7:0] WRAP_OPC_VAL = 8'h77;
	localparam logic [7:0] WRAP_LEN_VAL = 8'h64;
	localparam logic [15:0] LOCK_VAL = 16'hCBFC;

	// control register layout: qe bit0, wel bit1, suspend bit2, wrap length bits 5:4
	localparam int CTRL_QE_BIT = 0;
	localparam int CTRL_WEL_BIT = 1;
	localparam int CTRL_SUSP_BIT = 2;
	localparam int CTRL_WRAP_LO = 4;
	localparam logic [15:0] CTRL_RST = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OPCODE,
		ST_ADDR,
		ST_MODE,
		ST_DATA,
		ST_IGNORE
	} fmrc_state_e;

	typedef struct packed {
		logic four_line_command_mode;
		logic cont;
		logic armed;
		logic quad_rd;
	} fmrc_mode_s;

	typedef struct packed {
		logic [1:0] wrap;
		logic susp;
		logic wel;
		logic qe;
	} fmrc_ctrl_s;

	localparam fmrc_mode_s MODE_RST = '{four_line_command_mode: 1'b0, cont: 1'b0, armed: 1'b0, quad_rd: 1'b0};

endpackage : fmrc_pkg

// file: fmrc_top.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
module fmrc_top
	import fmrc_pkg::*;
(
	input wire logic MCLK_I, // system clock
	input wire logic RST_B_I, // sync reset, active low
	input wire logic SCLK_I, // serial link clock pin
	input wire logic CS_B_I, // chip select pin, active low
	input wire logic [3:0] IO_I, // serial io lines, input side
	input wire logic PE_BUSY_I, // program/erase in progress
	input wire logic [7:0] ADDR_I, // register address
	input wire logic [15:0] WDATA_I, // register write data
	input wire logic WR_I, // register write strobe
	input wire logic RD_I, // register read strobe
	output logic [15:0] RDATA_O, // register read data
	output logic QPI_MODE_O, // four-line command mode active
	output logic CONT_READ_O, // continuous read active
	output logic QE_O, // quad enable bit
	output logic WEL_O, // write enable latch
	output logic SUSPEND_O, // program/erase suspended
	output logic [1:0] WRAP_LEN_O, // wrap length setting
	output logic SW_RESET_O, // software reset pulse
	output logic PE_ABORT_O // program/erase abort pulse
);

	logic sclk_s1, sclk_s2, sclk_s3;
	logic cs_b_s1, cs_b_s2;
	logic [3:0] io_s1, io_s2;
	logic sclk_rise;
	logic cs_active;

	fmrc_state_e state_reg;
	logic [5:0] cnt_reg;
	logic [3:0] clk_reg;
	logic ones_reg;
	logic [7:0] op_reg;
	logic [7:0] mbits_reg;
	fmrc_mode_s mode_reg;
	fmrc_ctrl_s ctrl_reg;
	logic sw_rst_reg;
	logic abort_reg;
	logic [15:0] rdata_reg;

	logic [2:0] lanes;
	logic [5:0] cnt_next;
	logic [3:0] clk_next;
	logic ones_next;
	logic [7:0] op_next;
	logic [7:0] mbits_next;
	logic opc_done;
	logic mode_done;
	logic exit_hit;
	logic do_sw_reset;
	logic ctrl_wr;
	logic qe_eff;
	logic [15:0] rd_mux;

	// first stage feeds only the second; edge detect uses stages two and three
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			cs_b_s1 <= 1'b1;
			cs_b_s2 <= 1'b1;
			io_s1 <= 4'h0;
			io_s2 <= 4'h0;
		end else begin
			sclk_s1 <= SCLK_I;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			cs_b_s1 <= CS_B_I;
			cs_b_s2 <= cs_b_s1;
			io_s1 <= IO_I;
			io_s2 <= io_s1;
		end
	end

	assign sclk_rise = sclk_s2 & ~sclk_s3;
	assign cs_active = ~cs_b_s2;

	always_comb begin
		if (state_reg == ST_OPCODE) begin
			lanes = mode_reg.four_line_command_mode ? 3'h4 : 3'h1;
		end else begin
			lanes = mode_reg.quad_rd ? 3'h4 : 3'h2;
		end
	end

	assign cnt_next = cnt_reg + {3'h0, lanes};
	assign clk_next = (clk_reg == 4'hF) ? clk_reg : clk_reg + 4'h1;
	assign ones_next = ones_reg & (mode_reg.four_line_command_mode ? (&io_s2) : io_s2[0]);
	assign op_next = mode_reg.four_line_command_mode ? {op_reg[3:0], io_s2} : {op_reg[6:0], io_s2[0]};
	assign mbits_next = mode_reg.quad_rd ? {mbits_reg[3:0], io_s2} : {mbits_reg[5:0], io_s2[1:0]};
	assign opc_done = (state_reg == ST_OPCODE) && cs_active && sclk_rise && (cnt_next == OPC_BITS);
	assign mode_done = (state_reg == ST_MODE) && cs_active && sclk_rise && (cnt_next == MODE_BITS);

	// an all-ones address start inside the opcode window is taken as the exit code;
	// a real read at that address would carry all-ones mode bits and leave anyway
	assign exit_hit = mode_reg.cont && cs_active && sclk_rise && ones_next
		&& ((state_reg == ST_ADDR) || (state_reg == ST_MODE))
		&& (clk_next == (mode_reg.four_line_command_mode ? OPC_CLKS_QPI : OPC_CLKS_SPI));

	assign do_sw_reset = opc_done && (op_next == OP_RST_EXEC) && mode_reg.armed;
	assign ctrl_wr = WR_I && (ADDR_I == OFS_CTRL);
	assign qe_eff = ctrl_wr ? WDATA_I[CTRL_QE_BIT] : ctrl_reg.qe;

	// transaction sequencer
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 6'h00;
			clk_reg <= 4'h0;
			ones_reg <= 1'b1;
			op_reg <= 8'h00;
			mbits_reg <= 8'h00;
		end else if (!cs_active) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 6'h00;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					state_reg <= mode_reg.cont ? ST_ADDR : ST_OPCODE;
					cnt_reg <= 6'h00;
					clk_reg <= 4'h0;
					ones_reg <= 1'b1;
				end
				ST_OPCODE: begin
					if (sclk_rise) begin
						clk_reg <= clk_next;
						op_reg <= op_next;
						cnt_reg <= cnt_next;
						if (cnt_next == OPC_BITS) begin
							cnt_reg <= 6'h00;
							if ((op_next == OP_QUAD_READ) || (op_next == OP_DUAL_READ && !mode_reg.four_line_command_mode)) begin
								state_reg <= ST_ADDR;
							end else begin
								state_reg <= ST_IGNORE;
							end
						end
					end
				end
				ST_ADDR: begin
					if (sclk_rise) begin
						clk_reg <= clk_next;
						ones_reg <= ones_next;
						cnt_reg <= cnt_next;
						if (exit_hit) begin
							state_reg <= ST_IGNORE;
						end else if (cnt_next == ADDR_BITS) begin
							cnt_reg <= 6'h00;
							state_reg <= ST_MODE;
						end
					end
				end
				ST_MODE: begin
					if (sclk_rise) begin
						clk_reg <= clk_next;
						ones_reg <= ones_next;
						mbits_reg <= mbits_next;
						cnt_reg <= cnt_next;
						if (exit_hit) begin
							state_reg <= ST_IGNORE;
						end else if (cnt_next == MODE_BITS) begin
							state_reg <= ST_DATA;
						end
					end
				end
				ST_DATA: begin
					state_reg <= ST_DATA;
				end
				ST_IGNORE: begin
					state_reg <= ST_IGNORE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// mode state; later assignments take priority
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			mode_reg <= MODE_RST;
		end else if (do_sw_reset) begin
			mode_reg <= MODE_RST;
		end else begin
			if (opc_done) begin
				mode_reg.armed <= 1'b0;
				case (op_next)
					OP_CONT_EXIT: begin
						mode_reg.four_line_command_mode <= 1'b0;
						mode_reg.cont <= 1'b0;
					end
					OP_QPI_ENTER: begin
						if (qe_eff) begin
							mode_reg.four_line_command_mode <= 1'b1;
						end
					end
					OP_RST_ARM: begin
						mode_reg.armed <= 1'b1;
					end
					OP_QUAD_READ: begin
						mode_reg.quad_rd <= 1'b1;
					end
					OP_DUAL_READ: begin
						mode_reg.quad_rd <= mode_reg.four_line_command_mode;
					end
					default: begin
						mode_reg.armed <= 1'b0;
					end
				endcase
			end
			if (mode_done) begin
				// only bits 5:4 decide; the rest are don't-care
				mode_reg.cont <= (mbits_next[MODE_SKIP_HI:MODE_SKIP_LO] == CONT_KEEP);
			end
			if (exit_hit) begin
				mode_reg.cont <= 1'b0;
				mode_reg.four_line_command_mode <= 1'b0;
			end
			if (!qe_eff) begin
				mode_reg.four_line_command_mode <= 1'b0;
			end
		end
	end

	// control bits are untouched by qpi transitions
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			ctrl_reg <= fmrc_ctrl_s'(CTRL_RST[4:0]);
		end else if (do_sw_reset) begin
			ctrl_reg.wel <= 1'b0;
			ctrl_reg.susp <= 1'b0;
			ctrl_reg.wrap <= 2'h0;
			// qe survives the reset, so a write landing now must not be lost
			if (ctrl_wr) begin
				ctrl_reg.qe <= WDATA_I[CTRL_QE_BIT];
			end
		end else if (ctrl_wr) begin
			ctrl_reg.qe <= WDATA_I[CTRL_QE_BIT];
			ctrl_reg.wel <= WDATA_I[CTRL_WEL_BIT];
			ctrl_reg.susp <= WDATA_I[CTRL_SUSP_BIT];
			ctrl_reg.wrap <= WDATA_I[CTRL_WRAP_LO +: 2];
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			sw_rst_reg <= 1'b0;
			abort_reg <= 1'b0;
		end else begin
			sw_rst_reg <= do_sw_reset;
			abort_reg <= do_sw_reset & PE_BUSY_I;
		end
	end

	always_comb begin
		case (ADDR_I)
			OFS_VMAX: rd_mux = VMAX_VAL;
			OFS_VMIN: rd_mux = VMIN_VAL;
			OFS_FEAT: rd_mux = FEAT_VAL;
			OFS_WRAP_OPC: rd_mux = {8'h00, WRAP_OPC_VAL};
			OFS_WRAP_LEN: rd_mux = {8'h00, WRAP_LEN_VAL};
			OFS_LOCK: rd_mux = LOCK_VAL;
			OFS_CTRL: rd_mux = {10'h000, ctrl_reg.wrap, 1'b0, ctrl_reg.susp, ctrl_reg.wel, ctrl_reg.qe};
			OFS_STAT: rd_mux = {11'h000, PE_BUSY_I, mode_reg};
			default: rd_mux = 16'h0000;
		endcase
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			rdata_reg <= 16'h0000;
		end else begin
			rdata_reg <= RD_I ? rd_mux : 16'h0000;
		end
	end

	assign RDATA_O = rdata_reg;
	assign QPI_MODE_O = mode_reg.four_line_command_mode;
	assign CONT_READ_O = mode_reg.cont;
	assign QE_O = ctrl_reg.qe;
	assign WEL_O = ctrl_reg.wel;
	assign SUSPEND_O = ctrl_reg.susp;
	assign WRAP_LEN_O = ctrl_reg.wrap;
	assign SW_RESET_O = sw_rst_reg;
	assign PE_ABORT_O = abort_reg;

	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (!RST_B_I);

	a_qpi_needs_qe: assert property ($rose(mode_reg.four_line_command_mode) |-> ctrl_reg.qe && $past(state_reg) == ST_OPCODE)
		else $error("qpi entered without quad enable");
	a_qe_low_exit: assert property (!ctrl_reg.qe |-> !mode_reg.four_line_command_mode)
		else $error("qpi active while quad enable low");
	a_reset_after_arm: assert property (SW_RESET_O |-> $past(mode_reg.armed) && $past(opc_done))
		else $error("software reset without arm");
	a_reset_clears_mode: assert property (SW_RESET_O |-> !mode_reg.four_line_command_mode && !mode_reg.cont && !mode_reg.armed && !WEL_O)
		else $error("software reset left volatile state");
	a_abort_with_reset: assert property (PE_ABORT_O |-> SW_RESET_O && $past(PE_BUSY_I))
		else $error("abort without reset during busy");
	a_cont_from_mode: assert property ($rose(mode_reg.cont) |-> $past(state_reg) == ST_MODE && $past(mbits_next[5:4]) == 2'h2)
		else $error("continuous read set outside mode byte");
	a_cont_skips_opc: assert property (state_reg == ST_IDLE && cs_active && mode_reg.cont |=> state_reg == ST_ADDR)
		else $error("opcode phase entered in continuous read");
	a_abort_keeps_mode: assert property (state_reg == ST_OPCODE && !cs_active && !WR_I |=> $stable(mode_reg))
		else $error("partial opcode changed mode state");
	a_qpi_keeps_ctrl: assert property ($changed(mode_reg.four_line_command_mode) && !$past(ctrl_wr) && !$past(do_sw_reset) |-> $stable(ctrl_reg))
		else $error("qpi change disturbed control bits");
	a_read_one_cycle: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
		else $error("read data outside its cycle");
	a_qe_blocks_entry: assert property (opc_done && op_next == OP_QPI_ENTER && !qe_eff |=> !mode_reg.four_line_command_mode)
		else $error("qpi entered while quad enable low");
	a_arm_cleared: assert property (opc_done && op_next != OP_RST_ARM |=> !mode_reg.armed)
		else $error("armed state kept after other opcode");

endmodule : fmrc_top

// file: fmrc_host_model.sv
`timescale 1ns/1ns
module fmrc_host_model
	import fmrc_pkg::*;
(
	input wire logic clk_i, // system clock
	output logic sclk_o, // link clock, idle low
	output logic cs_b_o, // chip select, active low
	output logic [3:0] io_o // io lines towards the device
);
	initial begin
		sclk_o = 1'b0;
		cs_b_o = 1'b1;
		io_o = 4'h0;
	end
	// w lines per clock, n clocks, first bit on the highest line
	task automatic shift(input logic [31:0] v, input int n, input int w);
		logic [31:0] s;
		s = v << (32 - n * w);
		for (int i = 0; i < n; i++) begin
			io_o <= s[31:28] >> (4 - w);
			s = s << w;
			repeat (8) @(posedge clk_i);
			sclk_o <= 1'b1;
			repeat (8) @(posedge clk_i);
			sclk_o <= 1'b0;
		end
	endtask : shift
	task automatic start();
		@(posedge clk_i);
		cs_b_o <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : start
	task automatic stop();
		repeat (4) @(posedge clk_i);
		cs_b_o <= 1'b1;
		io_o <= ~io_o; // released lines keep no value
		repeat (24) @(posedge clk_i);
	endtask : stop
	// n below a full opcode gives a cut frame
	task automatic opcode(input logic [7:0] op, input logic four_line_command_mode, input int n);
		start();
		shift({24'h0, op} >> (8 - n * (four_line_command_mode ? 4 : 1)), n, four_line_command_mode ? 4 : 1);
		stop();
	endtask : opcode
	task automatic fast_read(input logic quad, input logic four_line_command_mode, input logic skip, input logic [23:0] a,
		input logic [7:0] m);
		start();
		if (!skip) begin
			shift({24'h0, quad ? OP_QUAD_READ : OP_DUAL_READ}, four_line_command_mode ? 2 : 8, four_line_command_mode ? 4 : 1);
		end
		shift({8'h0, a}, quad ? 6 : 12, quad ? 4 : 2);
		shift({24'h0, m}, quad ? 2 : 4, quad ? 4 : 2);
		stop();
	endtask : fast_read
endmodule : fmrc_host_model

// file: flash_mode_and_reset_control_tb_top.sv
`timescale 1ns/1ns
module flash_mode_and_reset_control_tb_top
	import fmrc_pkg::*;
;
	logic mclk, rst_b, sclk, cs_b, pe_busy, wr, rd, four_line_command_mode, cont, qe, wel, susp, swr, abrt;
	logic [3:0] io;
	logic [7:0] addr, m;
	logic [15:0] wdata, rdata, d;
	logic [1:0] wrap;
	logic [4:0] c;
	int fails = 0, n_checks = 0, seed = 65, n_rst = 0, n_abort = 0;
	logic [7:0] ofs [7] = '{8'h60, 8'h62, 8'h64, 8'h66, 8'h67, 8'h68, 8'h00};
	logic [15:0] exv [7] = '{16'h3600, 16'h2700, 16'hF99F, 16'h0077, 16'h0064, 16'hCBFC, 16'h0000};
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	fmrc_top fmrc_top_inst (.MCLK_I(mclk), .RST_B_I(rst_b), .SCLK_I(sclk), .CS_B_I(cs_b), .IO_I(io),
		.PE_BUSY_I(pe_busy), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.QPI_MODE_O(four_line_command_mode), .CONT_READ_O(cont), .QE_O(qe), .WEL_O(wel), .SUSPEND_O(susp),
		.WRAP_LEN_O(wrap), .SW_RESET_O(swr), .PE_ABORT_O(abrt));
	fmrc_host_model fmrc_host_model_inst (.clk_i(mclk), .sclk_o(sclk), .cs_b_o(cs_b), .io_o(io));
	always @(posedge mclk) begin
		if (swr === 1'b1) n_rst++;
		if (abrt === 1'b1) n_abort++;
	end
	task automatic wrap_up();
		if (fails == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (90000) @(posedge mclk);
		fails++;
		wrap_up();
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		@(posedge mclk);
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 v = rdata;
		@(posedge mclk);
	endtask : rd_reg
	task automatic chm(input logic eq, input logic ec);
		chk("qpi", {15'h0, eq}, {15'h0, four_line_command_mode});
		chk("cont", {15'h0, ec}, {15'h0, cont});
	endtask : chm
	task automatic ctl();
		chk("ctrl", {11'h0, c}, {11'h0, wrap, susp, wel, qe});
		rd_reg(OFS_CTRL, d);
		chk("ctrl readback", {10'h0, c[4:3], 1'b0, c[2:0]}, d);
	endtask : ctl
	task automatic setc(input logic [4:0] x);
		c = x;
		wr_reg(OFS_CTRL, {10'h0, c[4:3], 1'b0, c[2:0]});
		repeat (2) @(posedge mclk);
	endtask : setc
	initial begin
		rst_b = 1'b0;
		pe_busy = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		c = 5'h00;
		ctl();
		wr_reg(8'h64, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			rd_reg(ofs[i], d);
			chk("table", exv[i], d);
		end
		fmrc_host_model_inst.opcode(OP_CONT_EXIT, 1'b0, 8);
		setc(5'($random(seed)) & 5'h1E);
		fmrc_host_model_inst.opcode(OP_QPI_ENTER, 1'b0, 8);
		chm(1'b0, 1'b0);
		setc(c | 5'h01);
		fmrc_host_model_inst.opcode(OP_QPI_ENTER, 1'b0, 8);
		chm(1'b1, 1'b0);
		ctl();
		fmrc_host_model_inst.opcode(OP_CONT_EXIT, 1'b1, 2);
		chm(1'b0, 1'b0);
		ctl();
		fmrc_host_model_inst.opcode(OP_QPI_ENTER, 1'b0, 8);
		chm(1'b1, 1'b0);
		setc(c & 5'h1E);
		chm(1'b0, 1'b0);
		for (int i = 0; i < 8; i++) begin
			m = 8'($random(seed));
			m[5:4] = i[1:0];
			fmrc_host_model_inst.fast_read(i[2], 1'b0, 1'b0, {8'h00, 16'($random(seed))}, m);
			chm(1'b0, i[1:0] == 2'b10);
			if (i[1:0] == 2'b10) begin
				fmrc_host_model_inst.fast_read(i[2], 1'b0, 1'b1, 24'h001234, 8'hE0);
				chm(1'b0, 1'b1);
				fmrc_host_model_inst.fast_read(i[2], 1'b0, 1'b1, 24'h004321, 8'hCF);
				chm(1'b0, 1'b0);
			end
		end
		// reset pair arrives as read traffic here
		// dual read: an 8-clock frame stays inside the 12-clock address phase
		fmrc_host_model_inst.fast_read(1'b0, 1'b0, 1'b0, 24'h000F0F, 8'hA5);
		fmrc_host_model_inst.opcode(OP_RST_ARM, 1'b0, 8);
		fmrc_host_model_inst.opcode(OP_RST_EXEC, 1'b0, 8);
		chm(1'b0, 1'b1);
		chk("resets", 16'h0000, 16'(n_rst));
		fmrc_host_model_inst.opcode(OP_CONT_EXIT, 1'b0, 8);
		chm(1'b0, 1'b0);
		setc(5'h01);
		fmrc_host_model_inst.opcode(OP_QPI_ENTER, 1'b0, 8);
		fmrc_host_model_inst.fast_read(1'b1, 1'b1, 1'b0, 24'h00ABCD, 8'h20);
		chm(1'b1, 1'b1);
		rd_reg(OFS_STAT, d);
		chk("status", 16'h000D, d);
		fmrc_host_model_inst.opcode(OP_CONT_EXIT, 1'b1, 2);
		chm(1'b0, 1'b0);
		fmrc_host_model_inst.opcode(OP_RST_EXEC, 1'b0, 8);
		fmrc_host_model_inst.opcode(OP_RST_ARM, 1'b0, 8);
		fmrc_host_model_inst.opcode(8'h05, 1'b0, 8);
		fmrc_host_model_inst.opcode(OP_RST_EXEC, 1'b0, 8);
		chk("resets", 16'h0000, 16'(n_rst));
		setc(5'h1F);
		fmrc_host_model_inst.opcode(OP_QPI_ENTER, 1'b0, 8);
		fmrc_host_model_inst.opcode(OP_RST_ARM, 1'b1, 2);
		fmrc_host_model_inst.opcode(OP_RST_EXEC, 1'b1, 1);
		fmrc_host_model_inst.opcode(OP_RST_EXEC, 1'b1, 2);
		chk("resets", 16'h0001, 16'(n_rst));
		chk("aborts", 16'h0000, 16'(n_abort));
		chm(1'b0, 1'b0);
		c = 5'h01;
		ctl();
		pe_busy <= 1'b1;
		fmrc_host_model_inst.opcode(OP_RST_ARM, 1'b0, 8);
		fmrc_host_model_inst.opcode(OP_RST_EXEC, 1'b0, 8);
		pe_busy <= 1'b0;
		chk("resets", 16'h0002, 16'(n_rst));
		chk("aborts", 16'h0001, 16'(n_abort));
		wrap_up();
	end
endmodule : flash_mode_and_reset_control_tb_top
